// ==== src/osdc_color_gen.sv ====
// Character pixel colouring stage with palettes, enhanced features and serial register writes.
`timescale 1ns/1ps
`default_nettype none
`include "osdc_map.svh"
module osdc_color_gen (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic       scl_clk_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_o,
	input  wire logic       pix_valid_i,
	input  wire logic [7:0] char_code_i,
	input  wire logic [3:0] attr_i,
	input  wire logic       font_p0_i,
	input  wire logic       font_p1_i,
	input  wire logic [8:0] nbr_i,
	input  wire logic       top_row_i,
	input  wire logic       left_col_i,
	input  wire logic       frame_tick_i,
	output var  logic       pix_valid_o,
	output var  logic [8:0] rgb_o,
	output var  logic       transp_o,
	output var  logic [2:0] rom_bank_o,
	output var  logic [5:0] rom_char_o
);
	osdc_wr_if wr_link ();

	osdc_pkg::osdc_color_t c2_q [16][2];
	osdc_pkg::osdc_color_t c4_q [16][4];
	logic [7:0]            ft2_q [16];
	logic [7:0]            ft4_q [16];
	logic [7:0]            ef0_q;
	osdc_pkg::osdc_color_t hl_q;
	osdc_pkg::osdc_color_t ll_q;
	osdc_pkg::osdc_color_t sbh_q;
	logic [2:0]            bank_q [4];
	logic [2:0]            wr_sync_q;
	logic                  wr_seen_q;
	logic                  wr_evt;
	logic [15:0]           a_w;
	logic [7:0]            d_w;
	logic [6:0]            blink_cnt_q;
	logic                  blink_vis_q;
	logic [2:0]            bank_w;
	logic                  four_w;
	logic [7:0]            feat_w;
	logic [1:0]            idx_w;
	osdc_pkg::osdc_color_t base_w;
	osdc_pkg::osdc_color_t col0_w;
	osdc_pkg::osdc_color_t boxcol_w;
	osdc_pkg::osdc_color_t color_w;
	logic                  box_w;
	logic                  shadow_w;
	logic                  border_w;

	// Updates the low or high byte of a colour held as a 16-bit register pair.
	function automatic osdc_pkg::osdc_color_t set_col(input osdc_pkg::osdc_color_t old,
	                                                  input logic hi, input logic [7:0] d);
		set_col = hi ? {d[0], old[7:0]} : {old[8], d};
	endfunction

	// Banks 3 and 7 carry four-colour fonts, every other bank two-colour fonts.
	function automatic logic is_four(input logic [2:0] bank);
		is_four = (bank == `OSDC_BANK_4C_A) || (bank == `OSDC_BANK_4C_B);
	endfunction

	osdc_i2c_wr_slave u_slave (
		.reset_n_i (reset_n_i),
		.scl_clk_i (scl_clk_i),
		.sda_i     (sda_i),
		.sda_oe_o  (sda_oe_o),
		.wr        (wr_link.link_side)
	);

	// The pin only ever pulls low; the enable alone carries the acknowledge.
	assign sda_o = 1'b0;

	// Address and data stay put for a whole byte time after the toggle, so only the toggle is synchronised.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_sync_q <= 3'h0;
			wr_seen_q <= 1'b0;
		end else begin
			wr_sync_q <= {wr_sync_q[1:0], wr_link.wr_tog};
			if (wr_evt) begin
				wr_seen_q <= wr_sync_q[2];
			end
		end
	end

	assign wr_evt = (wr_sync_q[1] == wr_sync_q[2]) && (wr_sync_q[2] != wr_seen_q);
	assign a_w    = wr_link.wr_addr;
	assign d_w    = wr_link.wr_data;

	// Feature colours, the feature control byte and the bank selection registers.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ef0_q <= `OSDC_EF0_RESET;
			hl_q  <= `OSDC_COLOR_RESET;
			ll_q  <= `OSDC_COLOR_RESET;
			sbh_q <= `OSDC_COLOR_RESET;
			for (int i = 0; i < 4; i++) begin
				bank_q[i] <= `OSDC_BANK_RESET;
			end
		end else if (wr_evt) begin
			if (a_w == `OSDC_EF0_ADDR) begin
				ef0_q <= d_w;
			end
			if ((a_w == `OSDC_EF1_ADDR) || (a_w == `OSDC_EF1_ADDR + 16'h0001)) begin
				hl_q <= set_col(hl_q, a_w != `OSDC_EF1_ADDR, d_w);
			end
			if ((a_w == `OSDC_EF2_ADDR) || (a_w == `OSDC_EF2_ADDR + 16'h0001)) begin
				ll_q <= set_col(ll_q, a_w != `OSDC_EF2_ADDR, d_w);
			end
			if ((a_w == `OSDC_EF3_ADDR) || (a_w == `OSDC_EF3_ADDR + 16'h0001)) begin
				sbh_q <= set_col(sbh_q, a_w != `OSDC_EF3_ADDR, d_w);
			end
			if ((a_w >= `OSDC_BANK_ADDR) && (a_w < `OSDC_BANK_ADDR + 16'h0004)) begin
				bank_q[2'(a_w - `OSDC_BANK_ADDR)] <= d_w[2:0];
			end
		end
	end

	// Palette tables accept writes at any time, so colours can change while a frame is shown.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 16; i++) begin
				ft2_q[i] <= `OSDC_FEAT_RESET;
				ft4_q[i] <= `OSDC_FEAT_RESET;
				for (int j = 0; j < 2; j++) begin
					c2_q[i][j] <= `OSDC_COLOR_RESET;
				end
				for (int j = 0; j < 4; j++) begin
					c4_q[i][j] <= `OSDC_COLOR_RESET;
				end
			end
		end else if (wr_evt) begin
			if (a_w[15:6] == `OSDC_TAB2_PAGE) begin
				c2_q[a_w[5:2]][a_w[1]] <= set_col(c2_q[a_w[5:2]][a_w[1]], a_w[0], d_w);
			end
			if (a_w[15:7] == `OSDC_TAB4_PAGE) begin
				c4_q[a_w[6:3]][a_w[2:1]] <= set_col(c4_q[a_w[6:3]][a_w[2:1]], a_w[0], d_w);
			end
			if (a_w[15:4] == `OSDC_FEAT2_PAGE) begin
				ft2_q[a_w[3:0]] <= d_w;
			end
			if (a_w[15:4] == `OSDC_FEAT4_PAGE) begin
				ft4_q[a_w[3:0]] <= d_w;
			end
		end
	end

	// Blink phase flips after the programmed number of frames plus one.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			blink_cnt_q <= 7'h00;
			blink_vis_q <= 1'b1;
		end else if (frame_tick_i) begin
			if (blink_cnt_q >= ef0_q[7:`OSDC_EF0_RATE_LSB]) begin
				blink_cnt_q <= 7'h00;
				blink_vis_q <= ~blink_vis_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 7'h01;
			end
		end
	end

	// Pixel colour selection; boxes override everything, then shadow and border, then blink.
	always_comb begin
		bank_w   = bank_q[char_code_i[7:6]];
		four_w   = is_four(bank_w);
		feat_w   = four_w ? ft4_q[attr_i] : ft2_q[attr_i];
		idx_w    = four_w ? {font_p1_i, font_p0_i} : {1'b0, font_p0_i};
		base_w   = four_w ? c4_q[attr_i][idx_w] : c2_q[attr_i][idx_w[0]];
		col0_w   = four_w ? c4_q[attr_i][0] : c2_q[attr_i][0];
		box_w    = (feat_w[`OSDC_FT_BOX_TOP] && top_row_i) || (feat_w[`OSDC_FT_BOX_LEFT] && left_col_i);
		boxcol_w = !feat_w[`OSDC_FT_DEPRESSED] ? hl_q : (feat_w[`OSDC_FT_HEAVY] ? sbh_q : ll_q);
		// Shadow falls on background pixels lying below or right of a foreground pixel.
		shadow_w = !four_w && feat_w[`OSDC_FT_SHADOW] && !nbr_i[4] && (nbr_i[0] || nbr_i[1] || nbr_i[3]);
		border_w = !four_w && feat_w[`OSDC_FT_BORDER] && !nbr_i[4] && ((|nbr_i[3:0]) || (|nbr_i[8:5]));
		if (box_w) begin
			color_w = boxcol_w;
		end else if (shadow_w || border_w) begin
			color_w = sbh_q;
		end else if (feat_w[`OSDC_FT_BLINK] && !blink_vis_q) begin
			color_w = col0_w;
		end else begin
			color_w = base_w;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pix_valid_o <= 1'b0;
			rgb_o       <= `OSDC_COLOR_RESET;
			transp_o    <= 1'b0;
			rom_bank_o  <= 3'h0;
			rom_char_o  <= 6'h00;
		end else begin
			pix_valid_o <= pix_valid_i;
			rgb_o       <= color_w;
			// Only the lower half of the attribute range may punch through to live video.
			transp_o    <= pix_valid_i && ef0_q[`OSDC_EF0_TDIS_BIT] && !attr_i[3]
			               && (color_w == `OSDC_COLOR_BLACK);
			rom_bank_o  <= bank_w;
			rom_char_o  <= char_code_i[5:0];
		end
	end
endmodule
`default_nettype wire

// ==== src/osdc_i2c_wr_slave.sv ====
// Serial slave write port running on the bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "osdc_map.svh"
module osdc_i2c_wr_slave (
	input  wire logic           reset_n_i,
	input  wire logic           scl_clk_i,
	input  wire logic           sda_i,
	output var  logic           sda_oe_o,
	osdc_wr_if.link_side        wr
);
	logic                 start_tog_q;
	logic                 start_seen_q;
	logic [3:0]           bit_cnt_q;
	logic [6:0]           shift_q;
	osdc_pkg::osdc_phase_t phase_q;
	logic                 ack_ok_q;
	logic [15:0]          ptr_q;
	logic [7:0]           byte_w;

	assign byte_w = {shift_q, sda_i};

	// A start is the only SDA edge seen while SCL is high; a stop is simply ignored.
	always_ff @(negedge sda_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_tog_q <= 1'b0;
		end else if (scl_clk_i) begin
			start_tog_q <= ~start_tog_q;
		end
	end

	always_ff @(posedge scl_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_seen_q <= 1'b0;
			bit_cnt_q    <= 4'h0;
			shift_q      <= 7'h00;
			phase_q      <= osdc_pkg::OSDC_PH_IDLE;
			ack_ok_q     <= 1'b0;
			ptr_q        <= 16'h0000;
			wr.wr_tog    <= 1'b0;
			wr.wr_addr   <= 16'h0000;
			wr.wr_data   <= 8'h00;
		end else if (start_tog_q != start_seen_q) begin
			start_seen_q <= start_tog_q;
			bit_cnt_q    <= 4'h1;
			shift_q      <= {6'h00, sda_i};
			phase_q      <= osdc_pkg::OSDC_PH_ADDR;
			ack_ok_q     <= 1'b0;
		end else if (bit_cnt_q == `OSDC_BIT_ACK) begin
			bit_cnt_q <= 4'h0;
		end else begin
			shift_q   <= byte_w[6:0];
			bit_cnt_q <= bit_cnt_q + 4'h1;
			if (bit_cnt_q == `OSDC_BIT_LAST) begin
				unique case (phase_q)
					osdc_pkg::OSDC_PH_IDLE: begin
						ack_ok_q <= 1'b0;
					end
					osdc_pkg::OSDC_PH_ADDR: begin
						// Reads are acknowledged but return no data from this port.
						ack_ok_q <= (byte_w == `OSDC_SLAVE_WR) || (byte_w == `OSDC_SLAVE_RD);
						phase_q  <= (byte_w == `OSDC_SLAVE_WR) ? osdc_pkg::OSDC_PH_ALO : osdc_pkg::OSDC_PH_IDLE;
					end
					osdc_pkg::OSDC_PH_ALO: begin
						ack_ok_q    <= 1'b1;
						ptr_q[7:0]  <= byte_w;
						phase_q     <= osdc_pkg::OSDC_PH_AHI;
					end
					osdc_pkg::OSDC_PH_AHI: begin
						ack_ok_q    <= 1'b1;
						ptr_q[15:8] <= byte_w;
						phase_q     <= osdc_pkg::OSDC_PH_DATA;
					end
					osdc_pkg::OSDC_PH_DATA: begin
						ack_ok_q   <= 1'b1;
						wr.wr_addr <= ptr_q;
						wr.wr_data <= byte_w;
						wr.wr_tog  <= ~wr.wr_tog;
						ptr_q      <= ptr_q + 16'h0001;
					end
				endcase
			end
		end
	end

	// Driving on the falling edge keeps SDA stable across the rising edge the master samples.
	always_ff @(negedge scl_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sda_oe_o <= 1'b0;
		end else begin
			sda_oe_o <= (bit_cnt_q == `OSDC_BIT_ACK) && ack_ok_q;
		end
	end
endmodule
`default_nettype wire

// ==== src/osdc_map.svh ====
// Address map, field positions, reset values and fixed codes of the OSD character colour stage.
// Summary of operation
// - Banks 0, 1, 2, 4, 5 and 6 hold two-colour characters, one font bit each.
// - Two-colour pixel bit 0 selects colour 0, bit 1 selects colour 1.
// - Banks 3 and 7 hold four-colour characters, two bits per pixel.
// - Four-colour index takes plane 0 as LSB and plane 1 as MSB.
// - A 4-bit attribute beside the code picks one of 16 table entries.
// - Two-colour entries hold colours 0-1, four-colour entries colours 0-3.
// - Every palette colour is 9 bits, 3 bits each for red, green, blue.
// - Attribute tables stay writable over the serial port while displaying.
// - Transparent-disable makes black in attribute entries 0-7 transparent on every line.
// - Button boxes replace top row or left column; raised highlight, depressed lowlight.
// - Heavy boxes take depressed colour from the third feature colour register.
// - Shadowed two-colour characters get third-colour pixels below right of colour 1.
// - Bordered two-colour characters get third-colour pixels at every 0/1 transition.
// - Blinking swaps pixels outside boxes, shadows and borders to colour 0 at a programmed rate.
// - First byte 0xBA addresses a write, 0xBB a read.
// - The device pulls SDA low in every acknowledge bit of a transfer addressed to 0xBA, and after the 0xBB address byte.
// - Each further data byte goes to the next incremented address.
// - Code bits 7:6 select a bank register giving a 3-bit bank; bits 5:0 the character.
// - The bank number chosen decides between two-colour and four-colour tables.
`ifndef OSDC_MAP_SVH
`define OSDC_MAP_SVH

`define OSDC_SLAVE_WR      8'hBA
`define OSDC_SLAVE_RD      8'hBB

`define OSDC_EF0_ADDR      16'h8403
`define OSDC_EF1_ADDR      16'h8405
`define OSDC_EF2_ADDR      16'h8407
`define OSDC_EF3_ADDR      16'h8409
`define OSDC_BANK_ADDR     16'h8427
`define OSDC_TAB2_PAGE     10'h220
`define OSDC_TAB4_PAGE     9'h112
`define OSDC_FEAT2_PAGE    12'h8A0
`define OSDC_FEAT4_PAGE    12'h8A1

`define OSDC_EF0_TDIS_BIT  0
`define OSDC_EF0_RATE_LSB  1
`define OSDC_FT_BOX_TOP    0
`define OSDC_FT_BOX_LEFT   1
`define OSDC_FT_DEPRESSED  2
`define OSDC_FT_HEAVY      3
`define OSDC_FT_SHADOW     4
`define OSDC_FT_BORDER     5
`define OSDC_FT_BLINK      6

`define OSDC_BANK_4C_A     3'h3
`define OSDC_BANK_4C_B     3'h7
`define OSDC_COLOR_RESET   9'h000
`define OSDC_COLOR_BLACK   9'h000
`define OSDC_FEAT_RESET    8'h00
`define OSDC_EF0_RESET     8'h00
`define OSDC_BANK_RESET    3'h0
`define OSDC_BIT_LAST      4'h7
`define OSDC_BIT_ACK       4'h8

`endif

// ==== src/osdc_pkg.sv ====
// Types shared by the OSD colour stage and its serial write port.
package osdc_pkg;
	typedef enum logic [4:0] {
		OSDC_PH_IDLE = 5'h01,
		OSDC_PH_ADDR = 5'h02,
		OSDC_PH_ALO  = 5'h04,
		OSDC_PH_AHI  = 5'h08,
		OSDC_PH_DATA = 5'h10
	} osdc_phase_t;
	typedef logic [8:0] osdc_color_t;
endpackage

// ==== src/osdc_wr_if.sv ====
// Carrier for register writes passing from the serial clock domain to the system clock domain.
`timescale 1ns/1ps
`default_nettype none
interface osdc_wr_if;
	logic        wr_tog;
	logic [15:0] wr_addr;
	logic [7:0]  wr_data;
	modport link_side (output wr_tog, output wr_addr, output wr_data);
	modport core_side (input wr_tog, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// ==== verification/osdc_color_gen_checker.sv ====
// Port assertions of the OSD character colour stage.
`timescale 1ns/1ps
`default_nettype none
module osdc_color_gen_checker (
	input wire logic       clk_sys_i,
	input wire logic       reset_n_i,
	input wire logic       scl_clk_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       pix_valid_i,
	input wire logic [7:0] char_code_i,
	input wire logic [3:0] attr_i,
	input wire logic       pix_valid_o,
	input wire logic [8:0] rgb_o,
	input wire logic       transp_o,
	input wire logic [5:0] rom_char_o
);
	sequence ack_bit;
		$rose(sda_oe_o);
	endsequence
	sequence quiet_bits;
		!sda_oe_o [*8];
	endsequence
	reset_clear_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> rgb_o == 9'h000 && !transp_o) else $error("outputs not clear after reset");
	char_pass_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		pix_valid_i |=> rom_char_o == $past(char_code_i[5:0])) else $error("character index not passed");
	valid_pass_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		pix_valid_i |=> pix_valid_o) else $error("pixel valid not passed");
	transp_idle_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!pix_valid_i |=> !transp_o) else $error("transparency without pixel");
	transp_black_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		transp_o |-> rgb_o == 9'h000) else $error("transparency on a non-black colour");
	transp_attr_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		transp_o |-> $past(attr_i) < 4'h8) else $error("transparency on an upper attribute");
	sda_low_a: assert property (@(posedge scl_clk_i) disable iff (!reset_n_i)
		sda_oe_o |-> sda_o == 1'b0) else $error("data line driven high");
	ack_gap_a: assert property (@(posedge scl_clk_i) disable iff (!reset_n_i)
		ack_bit |=> quiet_bits) else $error("acknowledge not followed by a byte");
	ack_short_a: assert property (@(posedge scl_clk_i) disable iff (!reset_n_i)
		$fell(sda_oe_o) |-> !$past(sda_oe_o, 2)) else $error("acknowledge longer than one bit");
endmodule
bind osdc_color_gen osdc_color_gen_checker chk (.clk_sys_i, .reset_n_i, .scl_clk_i, .sda_o, .sda_oe_o,
	.pix_valid_i, .char_code_i, .attr_i, .pix_valid_o, .rgb_o, .transp_o, .rom_char_o);
`default_nettype wire

// ==== verification/osdc_i2c_master_model.sv ====
// Serial bus master model that writes the colour stage registers.
`timescale 1ns/1ps
`default_nettype none
module osdc_i2c_master_model (
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_low_o
);
	// The clock rests high between transfers, as an idle bus does.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic xfer(input logic [7:0] q[$], output int nacks);
		nacks = 0;
		#62.5 sda_low_o = 1'b1;
		#62.5 scl_o = 1'b0;
		foreach (q[i]) begin
			for (int b = 7; b >= 0; b--) begin
				#31.25 sda_low_o = !q[i][b];
				#31.25 scl_o = 1'b1;
				#62.5 scl_o = 1'b0;
			end
			#31.25 sda_low_o = 1'b0;
			#31.25 scl_o = 1'b1;
			#31.25 nacks += int'(sda_i !== 1'b0);
			#31.25 scl_o = 1'b0;
		end
		#31.25 sda_low_o = 1'b1;
		#31.25 scl_o = 1'b1;
		#62.5 sda_low_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== verification/test_osd_char_color_attr_gen.sv ====
// Self-checking bench of the OSD character colour stage.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, s); end end
module test_osd_char_color_attr_gen;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic [25:0]     pin = '0;
	logic            tick = 1'b0;
	wire logic       scl;
	wire logic       m_low;
	wire logic       oe;
	wire logic       sda;
	wire logic [8:0] rgb;
	wire logic       transp;
	wire logic [2:0] bank;
	wire logic [5:0] chr;
	int              failures = 0;
	int              check_count = 0;
	int              cyc = 0;
	// Open-drain wire with a pull-up: it reads high whenever nobody pulls it.
	assign sda = !(m_low || oe);
	osdc_color_gen uut (.clk_sys_i(clk), .reset_n_i(rst_n), .scl_clk_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
		.pix_valid_i(pin[25]), .char_code_i(pin[24:17]), .attr_i(pin[16:13]), .font_p1_i(pin[12]),
		.font_p0_i(pin[11]), .nbr_i(pin[10:2]), .top_row_i(pin[1]), .left_col_i(pin[0]), .frame_tick_i(tick),
		.pix_valid_o(), .rgb_o(rgb), .transp_o(transp), .rom_bank_o(bank), .rom_char_o(chr));
	osdc_i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
	initial begin
		forever #10 clk = !clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic px(input logic [7:0] c, input logic [3:0] a, input logic [1:0] pl, input logic [8:0] e,
		input logic [8:0] nb = 9'h000, input logic [1:0] tl = 2'b00, input logic et = 1'b0);
		@(posedge clk);
		pin <= {1'b1, c, a, pl, nb, tl};
		@(posedge clk);
		pin[25] <= 1'b0;
		#1;
		`CHK("rgb", e, rgb)
		`CHK("transp", et, transp)
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
		int n;
		logic [7:0] q[$];
		q = {8'hBA, a[7:0], a[15:8], d};
		m.xfer(q, n);
		`CHK("nacks", 0, n)
		// Writes cross a three-stage synchroniser, so allow time before looking.
		repeat (8) @(posedge clk);
	endtask
	task automatic pulse();
		@(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
	endtask
	task automatic t_reset();
		px(8'h45, 4'h0, 2'b01, 9'h000);
		`CHK("bank", 3'h0, bank)
		`CHK("char", 6'h05, chr)
		$display("test reset done");
	endtask
	task automatic t_two();
		wr(16'h8804, '{8'h00, 8'h00, 8'hAB, 8'h01, 8'hF0, 8'h00, 8'h55, 8'h01});
		px(8'h01, 4'h1, 2'b00, 9'h000);
		px(8'h01, 4'h1, 2'b11, 9'h1AB);
		px(8'h01, 4'h2, 2'b10, 9'h0F0);
		px(8'h01, 4'h2, 2'b01, 9'h155);
		$display("test two-colour done");
	endtask
	task automatic t_bank();
		logic [8:0] c4 [4];
		c4 = '{9'h011, 9'h122, 9'h033, 9'h144};
		wr(16'h8427, '{8'h05, 8'h03, 8'h07, 8'h02});
		wr(16'h8910, '{8'h11, 8'h00, 8'h22, 8'h01, 8'h33, 8'h00, 8'h44, 8'h01});
		for (int i = 0; i < 4; i++) begin
			px(8'h47, 4'h2, 2'(i), c4[i]);
		end
		`CHK("bank", 3'h3, bank)
		`CHK("char", 6'h07, chr)
		px(8'h8A, 4'h2, 2'b10, 9'h033);
		`CHK("bank", 3'h7, bank)
		px(8'hC1, 4'h2, 2'b01, 9'h155);
		px(8'h01, 4'h2, 2'b10, 9'h0F0);
		`CHK("bank", 3'h5, bank)
		$display("test banks done");
	endtask
	task automatic t_addr();
		int n;
		m.xfer('{8'hBC, 8'h04, 8'h88, 8'hFF}, n);
		`CHK("nacks", 4, n)
		m.xfer('{8'hBB}, n);
		`CHK("nacks", 0, n)
		repeat (8) @(posedge clk);
		px(8'h01, 4'h1, 2'b00, 9'h000);
		$display("test address done");
	endtask
	task automatic t_feat();
		logic [29:0] tab [9];
		tab = '{{8'h01, 2'b10, 9'h000, 2'b00, 9'h192}, {8'h02, 2'b10, 9'h000, 2'b01, 9'h1AB},
			{8'h02, 2'b01, 9'h000, 2'b01, 9'h192}, {8'h06, 2'b01, 9'h000, 2'b00, 9'h049},
			{8'h0E, 2'b01, 9'h000, 2'b00, 9'h124}, {8'h10, 2'b00, 9'h001, 2'b00, 9'h124},
			{8'h10, 2'b00, 9'h100, 2'b00, 9'h000}, {8'h20, 2'b00, 9'h100, 2'b00, 9'h124},
			{8'h20, 2'b00, 9'h000, 2'b00, 9'h000}};
		wr(16'h8405, '{8'h92, 8'h01, 8'h49, 8'h00, 8'h24, 8'h01});
		foreach (tab[i]) begin
			wr(16'h8A01, '{tab[i][29:22]});
			px(8'h01, 4'h1, tab[i][10:9], tab[i][8:0], tab[i][19:11], tab[i][21:20]);
		end
		$display("test features done");
	endtask
	task automatic t_blink();
		wr(16'h8A01, '{8'h41});
		px(8'h01, 4'h1, 2'b01, 9'h1AB, 9'h010);
		pulse();
		px(8'h01, 4'h1, 2'b01, 9'h000, 9'h010);
		px(8'h01, 4'h1, 2'b01, 9'h192, 9'h010, 2'b10);
		pulse();
		px(8'h01, 4'h1, 2'b01, 9'h1AB, 9'h010);
		// A rate of two holds each phase for three frame ticks.
		wr(16'h8403, '{8'h04});
		pulse();
		pulse();
		px(8'h01, 4'h1, 2'b01, 9'h1AB, 9'h010);
		pulse();
		px(8'h01, 4'h1, 2'b01, 9'h000, 9'h010);
		$display("test blink done");
	endtask
	task automatic t_transp();
		wr(16'h8403, '{8'h01});
		px(8'h01, 4'h1, 2'b00, 9'h000, 9'h000, 2'b00, 1'b1);
		px(8'h01, 4'h9, 2'b00, 9'h000);
		px(8'h01, 4'h2, 2'b00, 9'h0F0);
		$display("test transparency done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_two();
		t_bank();
		t_addr();
		t_feat();
		t_blink();
		t_transp();
		give_verdict();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end
endmodule
`default_nettype wire
